// ### roam_pkg.sv
// Package for the ready-output acknowledgement monitor
package roam_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned ACK_WINDOW_MS  = 146;
    localparam int unsigned ACK_WINDOW_CYC =
        32'((ACK_WINDOW_MS * 64'd1000000000) / CLK_PERIOD_PS);
    localparam int unsigned WIN_CNT_W      = 26;
    localparam int unsigned BLINK_MS       = 250;
    localparam int unsigned BLINK_CYC      =
        32'((BLINK_MS * 64'd1000000000) / CLK_PERIOD_PS);
    localparam int unsigned NUM_CHAN       = 3;

    // ************************************************************
    // Channel indices in the fault report
    // ************************************************************
    localparam int unsigned CH_COMM = 0;
    localparam int unsigned CH_GEOM = 1;
    localparam int unsigned CH_LOGIC = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic RDY_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_POWER_NOTICE,
        ST_WAIT_VOLTAGE,
        ST_DROP_TEST,
        ST_RESTORE,
        ST_RUN,
        ST_HALT
    } roam_state_t;

    // Error indications shown to the operator
    typedef struct packed {
        logic                power_loss_notice;
        logic                ext_relay_voltage_absent;
        logic                estop_loop_fault;
        logic                estop_active_error;
        logic                diag_fault;
        logic [NUM_CHAN-1:0] fault_chan;
    } roam_err_t;

endpackage : roam_pkg

// ### roam_win_timer.sv
// Window counter for the acknowledgement drop check
`timescale 1ns/10ps
module roam_win_timer
    import roam_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic start,
    input  wire logic stop,
    output logic      busy_q,
    output logic      expired_q
);

    logic [WIN_CNT_W-1:0] cnt_q;

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt_q     <= '0;
            busy_q    <= 1'b0;
            expired_q <= 1'b0;
        end else if (start) begin
            cnt_q     <= '0;
            busy_q    <= 1'b1;
            expired_q <= 1'b0;
        end else if (busy_q && stop) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            if (cnt_q == WIN_CNT_W'(ACK_WINDOW_CYC - 1)) begin
                busy_q    <= 1'b0;
                expired_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end else begin
            expired_q <= 1'b0;
        end
    end

endmodule : roam_win_timer

// ### roam_monitor.sv
// Ready-for-operation output and acknowledgement monitor
`timescale 1ns/10ps
module roam_monitor
    import roam_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                ack_in,
    input  wire logic                io_supply_ok,
    input  wire logic                clear_key,
    input  wire logic [NUM_CHAN-1:0] diag_fault_in,
    input  wire logic [NUM_CHAN-1:0] chan_present,
    output logic                     ready_out_q,
    output logic                     blink_q,
    output roam_err_t                err_q
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0]          ack_s_q;
    logic [1:0]          sup_s_q;
    logic [1:0]          clr_s_q;
    logic [NUM_CHAN-1:0] diag_m_q;
    logic [NUM_CHAN-1:0] diag_s_q;
    logic                clr_d1_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ack_s_q  <= '0;
            sup_s_q  <= '0;
            clr_s_q  <= '0;
            diag_m_q <= '0;
            diag_s_q <= '0;
            clr_d1_q <= 1'b0;
        end else begin
            ack_s_q  <= {ack_s_q[0], ack_in};
            sup_s_q  <= {sup_s_q[0], io_supply_ok};
            clr_s_q  <= {clr_s_q[0], clear_key};
            diag_m_q <= diag_fault_in;
            diag_s_q <= diag_m_q;
            clr_d1_q <= clr_s_q[1];
        end
    end

    logic ack_ok;
    logic sup_ok;
    logic clr_press;
    logic any_diag;

    assign ack_ok    = ack_s_q[1];
    assign sup_ok    = sup_s_q[1];
    assign clr_press = clr_s_q[1] & ~clr_d1_q;
    assign any_diag  = |(diag_s_q & chan_present);

    // ************************************************************
    // Switch-on sequence
    // ************************************************************
    roam_state_t                state_q;
    logic [1:0]                 chan_q;
    logic                       win_start;
    logic                       win_busy;
    logic                       win_exp;
    logic                       pwr_seen_q;

    // Next channel present in the larger variant, or done
    function automatic logic [1:0] next_chan(input logic [1:0] c,
                                             input logic [NUM_CHAN-1:0] pres);
        logic [1:0] n;
        n = 2'(NUM_CHAN);
        // Walk down so the lowest present channel above c wins
        for (int i = int'(NUM_CHAN) - 1; i >= 0; i--) begin
            if (i > int'(c) && pres[i]) begin
                n = 2'(i);
            end
        end
        return n;
    endfunction : next_chan

    assign win_start = (state_q == ST_WAIT_VOLTAGE) && ack_ok && sup_ok;

    roam_win_timer u_win (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .start     (win_start),
        .stop      (~ack_ok),
        .busy_q    (win_busy),
        .expired_q (win_exp)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q    <= ST_POWER_NOTICE;
            chan_q     <= 2'(CH_COMM);
            pwr_seen_q <= 1'b0;
        end else if (any_diag || (!sup_ok && state_q != ST_POWER_NOTICE)) begin
            // Supply still settling right after reset, so the notice state is spared
            state_q <= ST_HALT;
        end else begin
            case (state_q)
                ST_POWER_NOTICE: begin
                    // Operator acknowledges the power loss notice first
                    if (clr_press) begin
                        state_q    <= ST_WAIT_VOLTAGE;
                        pwr_seen_q <= 1'b1;
                        chan_q     <= chan_present[0] ? 2'(CH_COMM)
                                                      : next_chan(2'(CH_COMM), chan_present);
                    end
                end
                ST_WAIT_VOLTAGE: begin
                    if (!sup_ok) begin
                        state_q <= ST_HALT;
                    end else if (ack_ok) begin
                        state_q <= ST_DROP_TEST;
                    end
                end
                ST_DROP_TEST: begin
                    if (win_exp) begin
                        state_q <= ST_HALT;
                    end else if (!win_busy && !ack_ok) begin
                        state_q <= ST_RESTORE;
                    end
                end
                ST_RESTORE: begin
                    // Wait for the loop to close again, else run would trip at once
                    if (!ack_ok) begin
                        state_q <= ST_RESTORE;
                    end else if (next_chan(chan_q, chan_present) >= 2'(NUM_CHAN)) begin
                        state_q <= ST_RUN;
                    end else begin
                        chan_q  <= next_chan(chan_q, chan_present);
                        state_q <= ST_WAIT_VOLTAGE;
                    end
                end
                ST_RUN: begin
                    if (any_diag || !ack_ok || !sup_ok) begin
                        state_q <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    // Cleared only when no diagnostic fault remains and the supply is back; ack is not checked
                    if (clr_press && !any_diag && sup_ok) begin
                        state_q <= ST_WAIT_VOLTAGE;
                        chan_q  <= chan_present[0] ? 2'(CH_COMM)
                                                   : next_chan(2'(CH_COMM), chan_present);
                    end
                end
                default: state_q <= ST_POWER_NOTICE;
            endcase
        end
    end

    // ************************************************************
    // Ready output
    // ************************************************************
    // Ready must drop in the same cycle the fault flag rises
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ready_out_q <= RDY_RST;
        end else if (any_diag || !sup_ok) begin
            ready_out_q <= 1'b0;
        end else begin
            case (state_q)
                ST_WAIT_VOLTAGE: ready_out_q <= ack_ok ? 1'b0 : 1'b1;
                ST_DROP_TEST:    ready_out_q <= 1'b0;
                ST_RESTORE:      ready_out_q <= 1'b1;
                ST_RUN:          ready_out_q <= ack_ok && sup_ok;
                default:         ready_out_q <= 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Error indications
    // ************************************************************
    logic [25:0]         blink_cnt_q;
    logic                err_blinks;
    logic                notice_q;
    logic                absent_q;
    logic                loop_q;
    logic                active_q;
    logic                diag_q;
    logic [NUM_CHAN-1:0] chan_fail_q;
    logic                halt_clear;

    // One clear for all latched errors, matching the exit from halt
    assign halt_clear = (state_q == ST_HALT) && clr_press && !any_diag && sup_ok;
    assign err_blinks = diag_q | loop_q;
    assign err_q      = {notice_q, absent_q, loop_q, active_q, diag_q, chan_fail_q};

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            notice_q <= 1'b0;
        end else begin
            notice_q <= (state_q == ST_POWER_NOTICE) && !clr_press;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            absent_q <= 1'b0;
        end else begin
            absent_q <= (state_q == ST_WAIT_VOLTAGE) && !ack_ok;
        end
    end

    // Set wins over the clear key in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            diag_q <= 1'b0;
        end else if (any_diag) begin
            diag_q <= 1'b1;
        end else if (halt_clear) begin
            diag_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            loop_q <= 1'b0;
        end else if ((state_q == ST_DROP_TEST && win_exp)
                     || (state_q != ST_POWER_NOTICE && !sup_ok)) begin
            loop_q <= 1'b1;
        end else if (halt_clear) begin
            loop_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            chan_fail_q <= '0;
        end else if (state_q == ST_DROP_TEST && win_exp) begin
            chan_fail_q <= chan_fail_q | (NUM_CHAN'(1) << chan_q);
        end else if (halt_clear) begin
            chan_fail_q <= '0;
        end
    end

    // Ack is only restored through the wait state, so the clear cannot ask for it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            active_q <= 1'b0;
        end else if (state_q == ST_RUN && !ack_ok) begin
            active_q <= 1'b1;
        end else if (halt_clear) begin
            active_q <= 1'b0;
        end
    end

    // Blink cadence, phase only matters to the display
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (!err_blinks) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == 26'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 26'd1;
            if (!pwr_seen_q) begin
                blink_q <= blink_q;
            end
        end
    end

endmodule : roam_monitor

// ### roam_monitor_assertions.sv
// Concurrent checks on the ports of the ready-output monitor
`timescale 1ns/10ps
module roam_monitor_chk
    import roam_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rst_b,
    input wire logic                ack_in,
    input wire logic                io_supply_ok,
    input wire logic [NUM_CHAN-1:0] diag_fault_in,
    input wire logic [NUM_CHAN-1:0] chan_present,
    input wire logic                ready_out_q,
    input wire logic                blink_q,
    input wire roam_err_t           err_q
);
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Two sync flops plus the ready and fault flag registers give the figure of three
    diag_drop_a: assert property ($rose(|(diag_fault_in & chan_present))
        ##1 (|(diag_fault_in & chan_present))[*3]
        |-> !ready_out_q && err_q.diag_fault) else $error("ready kept on after fault");
    fault_ready_a: assert property ((err_q.diag_fault || err_q.estop_loop_fault
        || err_q.estop_active_error) |-> !ready_out_q) else $error("ready on with fault");
    blink_cause_a: assert property ($rose(blink_q)
        |-> err_q.diag_fault || err_q.estop_loop_fault) else $error("blink without fault");
    notice_ready_a: assert property (err_q.power_loss_notice
        |-> !ready_out_q && !err_q.ext_relay_voltage_absent) else $error("notice state bad");
    absent_clear_a: assert property ((err_q.ext_relay_voltage_absent && ack_in
        && io_supply_ok)[*3] |-> ##[0:2] !err_q.ext_relay_voltage_absent)
        else $error("absent flag stuck");
    drop_test_a: assert property ($fell(err_q.ext_relay_voltage_absent)
        |-> ##[0:2] !ready_out_q) else $error("no ready drop for test");
    chan_valid_a: assert property ((err_q.fault_chan & ~chan_present) == 3'h0)
        else $error("absent channel reported");
    chan_single_a: assert property ($onehot0(err_q.fault_chan))
        else $error("several channels reported");

    cover property (err_q.ext_relay_voltage_absent ##[1:1000] !ready_out_q);
    cover property ($rose(err_q.estop_active_error));
    cover property ($rose(err_q.diag_fault));
    cover property ($rose(err_q.estop_loop_fault));
endmodule : roam_monitor_chk

bind roam_monitor roam_monitor_chk roam_monitor_chk_i (
    .core_clk(core_clk), .rst_b(rst_b), .ack_in(ack_in), .io_supply_ok(io_supply_ok),
    .diag_fault_in(diag_fault_in), .chan_present(chan_present),
    .ready_out_q(ready_out_q), .blink_q(blink_q), .err_q(err_q));

// ### roam_relay_model.sv
// External relay loop feeding the acknowledgement back
`timescale 1ns/10ps
module roam_relay_model (
    input  wire logic core_clk,
    input  wire logic ready_out_q,
    input  wire logic volt_on,
    output logic      ack
);
    // ************************************************************
    // Contactor delay line
    // ************************************************************
    // Slow contactor, still far inside the window; line falls to 0 V when off
    logic [3:0] pipe_q = 4'h0;
    always_ff @(posedge core_clk) begin
        pipe_q <= {pipe_q[2:0], volt_on && ready_out_q};
    end
    assign ack = pipe_q[3];
endmodule : roam_relay_model

// ### ready_output_ack_monitor_tb.sv
// Self-checking bench for the ready-output monitor
`timescale 1ns/10ps
module ready_output_ack_monitor_tb;
    import roam_pkg::*;
    logic                core_clk;
    logic                rst_b;
    logic                ack_in;
    logic                io_supply_ok;
    logic                clear_key;
    logic [NUM_CHAN-1:0] diag_fault_in;
    logic [NUM_CHAN-1:0] chan_present;
    logic                ready_out_q;
    logic                blink_q;
    roam_err_t           err_q;
    logic                volt_on;
    int                  err_total = 0;
    int                  n_tests = 0;

    roam_monitor roam_monitor_i (.core_clk(core_clk), .rst_b(rst_b), .ack_in(ack_in),
        .io_supply_ok(io_supply_ok), .clear_key(clear_key), .diag_fault_in(diag_fault_in),
        .chan_present(chan_present), .ready_out_q(ready_out_q), .blink_q(blink_q),
        .err_q(err_q));
    roam_relay_model roam_relay_model_i (.core_clk(core_clk), .ready_out_q(ready_out_q),
        .volt_on(volt_on), .ack(ack_in));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic press_clear;
        clear_key <= 1'b1;
        repeat (3) @(posedge core_clk);
        clear_key <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : press_clear

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic reset_dut(input logic [2:0] chans);
        rst_b <= 1'b0;
        volt_on <= 1'b0;
        chan_present <= chans;
        repeat (8) @(posedge core_clk);
        chk(8'(err_q), 8'h00);
        chk({6'h0, ready_out_q, blink_q}, 8'h00);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({6'h0, err_q.power_loss_notice, ready_out_q}, 8'h02);
    endtask : reset_dut

    task automatic startup;
        press_clear();
        chk({6'h0, err_q.ext_relay_voltage_absent, ready_out_q}, 8'h03);
        volt_on <= 1'b1;
        for (int i = 0; i < 40 && ready_out_q; i++) @(posedge core_clk);
        chk({7'h0, ready_out_q}, 8'h00);
        repeat (300) @(posedge core_clk);
        chk(8'(err_q), 8'h00);
        chk({7'h0, ready_out_q}, 8'h01);
    endtask : startup

    // After the clear the monitor waits for voltage again with ready on
    task automatic t_run_loss;
        volt_on <= 1'b0;
        for (int i = 0; i < 40 && ready_out_q; i++) @(posedge core_clk);
        chk({6'h0, err_q.estop_active_error, ready_out_q}, 8'h02);
        press_clear();
        chk(8'(err_q), 8'h40);
        chk({7'h0, ready_out_q}, 8'h01);
    endtask : t_run_loss

    task automatic t_diag;
        diag_fault_in <= 3'h2;
        repeat (5) @(posedge core_clk);
        chk({6'h0, err_q.diag_fault, ready_out_q}, 8'h02);
        press_clear();
        chk({6'h0, err_q.diag_fault, ready_out_q}, 8'h02);
        diag_fault_in <= 3'h0;
        repeat (4) @(posedge core_clk);
        press_clear();
        chk({7'h0, err_q.diag_fault}, 8'h00);
    endtask : t_diag

    task automatic t_supply;
        io_supply_ok <= 1'b0;
        for (int i = 0; i < 40 && ready_out_q; i++) @(posedge core_clk);
        chk({6'h0, err_q.estop_loop_fault, ready_out_q}, 8'h02);
        io_supply_ok <= 1'b1;
    endtask : t_supply

    // ************************************************************
    // Clock, watchdog and main sequence
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Whole run needs little more than a thousand cycles; twenty thousand is ample
    initial begin
        #80000;
        err_total++;
        test_done();
    end

    initial begin
        rst_b = 1'b0;
        io_supply_ok = 1'b1;
        clear_key = 1'b0;
        diag_fault_in = 3'h0;
        chan_present = 3'h7;
        volt_on = 1'b0;
        @(posedge core_clk);
        reset_dut(3'h7);
        startup();
        t_run_loss();
        reset_dut(3'h7);
        startup();
        t_diag();
        reset_dut(3'h1);
        startup();
        t_supply();
        test_done();
    end
endmodule : ready_output_ack_monitor_tb
